// file: include/irq_pkg.sv
// Constants, types and layouts for the interrupt priority, mask and accept block
// Overview of operation
// - Mask clear register is 32-bit write-only and reads back as zero.
// - Writing 1 to a mask clear bit clears that mask bit; 0 leaves it.
// - Pending, mask and mask clear share one map: bit 9 timer4, bit 8 timer3.
// - Highest programmed level wins; lower requests stay pending.
// - Equal levels are resolved by a fixed built-in source order.
// - Forward only when selected level is strictly above the CPU mask level.
// - The CPU takes a forwarded interrupt only at an instruction boundary.
// - On acceptance the source code is loaded into the event code register.
// - On acceptance state, PC and stack pointer are copied to saved registers.
// - On acceptance block, privilege and bank select bits of state become 1.
// - After saving, fetch starts at vector base plus the fixed handler offset.
// - Acceptance leaves the CPU four-bit mask level field unchanged.
// - With mask-all-on-NMI-low set, every source except NMI is masked while the NMI pin is low.
// - With that bit set, NMI edges still raise NMI in normal and sleep modes.
// - With that bit set in standby, NMI edges raise nothing.
// - Decision takes one core cycle plus 4, 7 or 2 bus cycles by source type.
// - After the instruction wait, exception entry takes four core cycles.
// - With block bit clear, a level above the mask level is accepted, nesting.
// - Source mask resets to low ten bits set; writing 0 has no effect.
// - Pending bits show requests whether or not the source is masked.
// - Level zero masks a source; level fifteen is the highest programmable level, and NMI sits fixed at sixteen.
package irq_pkg;

   localparam logic [7:0] OFF_SOURCE_MASK = 8'h00;
   localparam logic [7:0] OFF_MASK_CLEAR = 8'h04;
   localparam logic [7:0] OFF_SOURCE_PENDING = 8'h08;
   localparam logic [7:0] OFF_LEVEL_SET = 8'h0c;
   localparam logic [7:0] OFF_CONTROL = 8'h10;
   localparam logic [7:0] OFF_EVENT_CODE = 8'h14;
   localparam logic [7:0] OFF_SAVED_STATE = 8'h18;
   localparam logic [7:0] OFF_SAVED_PC = 8'h1c;
   localparam logic [7:0] OFF_SAVED_STACK = 8'h20;

   localparam logic [31:0] MASK_RESET = 32'h000003ff;
   localparam logic [31:0] SOURCE_BITS = 32'h00000300;
   localparam int TIMER4_BIT = 9;
   localparam int TIMER3_BIT = 8;
   localparam logic [31:0] LEVEL_RW_MASK = 32'h0000ff00;
   localparam int TIMER4_LEVEL_LSB = 12;
   localparam int TIMER3_LEVEL_LSB = 8;
   localparam logic [31:0] CONTROL_RW_MASK = 32'h00000001;
   localparam int CONTROL_MAI_BIT = 0;

   localparam int STATE_MD_BIT = 30;
   localparam int STATE_RB_BIT = 29;
   localparam int STATE_BL_BIT = 28;
   localparam int STATE_CPU_IRQ_MASK_FIELD_LSB = 4;
   localparam logic [31:0] HANDLER_OFFSET = 32'h00000600;

   localparam logic [4:0] NMI_LEVEL = 5'h10;
   localparam logic [3:0] ENC_IDLE = 4'hf;

   localparam logic [31:0] EVT_NMI = 32'h00000010;
   localparam logic [31:0] EVT_ENCODED = 32'h00000200;
   localparam logic [31:0] EVT_TIMER3 = 32'h00000300;
   localparam logic [31:0] EVT_TIMER4 = 32'h00000320;

   localparam int CORE_PERIOD_NS = 100;
   localparam int BUS_PERIOD_NS = 200;
   localparam logic [3:0] BUS_DIV = 4'((BUS_PERIOD_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS);
   localparam logic [3:0] LAT_NMI_BUS = 4'h4;
   localparam logic [3:0] LAT_ENC_BUS = 4'h7;
   localparam logic [3:0] LAT_PERIPH_BUS = 4'h2;
   localparam logic [3:0] ENTRY_CORE = 4'h4;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      SRC_NMI = 2'b00,
      SRC_ENC = 2'b01,
      SRC_TMR3 = 2'b10,
      SRC_TMR4 = 2'b11
   } src_t;

   typedef enum logic [1:0] {
      PH_IDLE = 2'b00,
      PH_DECIDE = 2'b01,
      PH_WAIT = 2'b10,
      PH_ENTRY = 2'b11
   } phase_t;

   typedef struct packed {
      logic [31:0] state;
      logic [31:0] pc;
      logic [31:0] stack;
      logic [31:0] vbase;
      logic boundary;
   } cpu_view_t;

   typedef struct packed {
      logic [31:0] saved_state;
      logic [31:0] saved_pc;
      logic [31:0] saved_stack;
      logic [31:0] new_state;
      logic [31:0] fetch_addr;
      logic take;
      logic fetch_start;
   } cpu_entry_t;

endpackage

// file: hdl/irq_arbiter.sv
// Highest-level priority arbiter over four sources, fixed order on ties
`timescale 1ns/1ps
module irq_arbiter (
   input wire logic [3:0] req,
   input wire logic [3:0][4:0] lvl,
   output logic sel_valid,
   output irq_pkg::src_t sel_src,
   output logic [4:0] sel_lvl
);

   always_comb begin
      sel_valid = 1'b0;
      sel_src = irq_pkg::SRC_NMI;
      sel_lvl = 5'h00;
      // Lower index wins ties
      for (int i = 3; i >= 0; i--) begin
         if (req[i] && (!sel_valid || lvl[i] >= sel_lvl)) begin
            sel_valid = 1'b1;
            sel_src = irq_pkg::src_t'(2'(i));
            sel_lvl = lvl[i];
         end
      end
   end

endmodule

// file: hdl/irq_priority_mask_accept.sv
// Interrupt priority, masking and CPU acceptance with an AXI4-Lite register slave
`timescale 1ns/1ps
module irq_priority_mask_accept (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [7:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire logic nmi_pin,
   input wire logic [3:0] encoded_request_pins,
   input wire logic timer3_underflow_irq,
   input wire logic timer4_underflow_irq,
   input wire logic standby_mode,
   input wire irq_pkg::cpu_view_t cpu,
   output logic irq_request,
   output irq_pkg::cpu_entry_t cpu_entry
);

   typedef struct packed {
      logic aw_held;
      logic [7:0] aw_addr;
      logic w_held;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic b_valid;
      logic [1:0] b_resp;
      logic r_valid;
      logic [31:0] r_data;
      logic [1:0] r_resp;
      logic [31:0] source_mask;
      logic [31:0] level_set;
      logic [31:0] control;
      logic [31:0] event_code;
      logic nmi_prev;
      logic nmi_pend;
      irq_pkg::phase_t phase;
      irq_pkg::src_t src;
      logic [3:0] count;
      logic [3:0] div;
      irq_pkg::cpu_entry_t entry;
   } state_t;

   state_t state_reg;
   state_t state_next;

   logic [31:0] pending;
   logic mai_mask;
   logic [3:0] req;
   logic [3:0][4:0] lvl;
   logic sel_valid;
   irq_pkg::src_t sel_src;
   logic [4:0] sel_lvl;
   logic blocked;
   logic [3:0] cpu_irq_mask_field;
   logic acceptable;
   logic bus_tick;
   logic nmi_edge;

   function automatic logic [31:0] byte_mask(input logic [3:0] strb);
      byte_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
         input logic [3:0] strb);
      merge = (old & ~byte_mask(strb)) | (data & byte_mask(strb));
   endfunction

   function automatic logic mapped(input logic [7:0] addr);
      case (addr)
         irq_pkg::OFF_SOURCE_MASK, irq_pkg::OFF_MASK_CLEAR, irq_pkg::OFF_SOURCE_PENDING,
         irq_pkg::OFF_LEVEL_SET, irq_pkg::OFF_CONTROL, irq_pkg::OFF_EVENT_CODE,
         irq_pkg::OFF_SAVED_STATE, irq_pkg::OFF_SAVED_PC, irq_pkg::OFF_SAVED_STACK: mapped = 1'b1;
         default: mapped = 1'b0;
      endcase
   endfunction

   function automatic logic [3:0] bus_latency(input irq_pkg::src_t s);
      case (s)
         irq_pkg::SRC_NMI: bus_latency = irq_pkg::LAT_NMI_BUS;
         irq_pkg::SRC_ENC: bus_latency = irq_pkg::LAT_ENC_BUS;
         default: bus_latency = irq_pkg::LAT_PERIPH_BUS;
      endcase
   endfunction

   function automatic logic [31:0] event_of(input irq_pkg::src_t s);
      case (s)
         irq_pkg::SRC_NMI: event_of = irq_pkg::EVT_NMI;
         irq_pkg::SRC_ENC: event_of = irq_pkg::EVT_ENCODED;
         irq_pkg::SRC_TMR3: event_of = irq_pkg::EVT_TIMER3;
         default: event_of = irq_pkg::EVT_TIMER4;
      endcase
   endfunction

   // Source side
   assign pending = {22'h000000, timer4_underflow_irq, timer3_underflow_irq, 8'h00};
   assign mai_mask = state_reg.control[irq_pkg::CONTROL_MAI_BIT] && !nmi_pin;
   assign nmi_edge = state_reg.nmi_prev && !nmi_pin;

   always_comb begin
      lvl[irq_pkg::SRC_NMI] = irq_pkg::NMI_LEVEL;
      lvl[irq_pkg::SRC_ENC] = {1'b0, ~encoded_request_pins};
      lvl[irq_pkg::SRC_TMR3] = {1'b0, state_reg.level_set[irq_pkg::TIMER3_LEVEL_LSB +: 4]};
      lvl[irq_pkg::SRC_TMR4] = {1'b0, state_reg.level_set[irq_pkg::TIMER4_LEVEL_LSB +: 4]};
      req[irq_pkg::SRC_NMI] = state_reg.nmi_pend;
      req[irq_pkg::SRC_ENC] = (encoded_request_pins != irq_pkg::ENC_IDLE) && !mai_mask;
      req[irq_pkg::SRC_TMR3] = pending[irq_pkg::TIMER3_BIT] && !state_reg.source_mask[irq_pkg::TIMER3_BIT]
         && (lvl[irq_pkg::SRC_TMR3] != 5'h00) && !mai_mask;
      req[irq_pkg::SRC_TMR4] = pending[irq_pkg::TIMER4_BIT] && !state_reg.source_mask[irq_pkg::TIMER4_BIT]
         && (lvl[irq_pkg::SRC_TMR4] != 5'h00) && !mai_mask;
   end

   irq_arbiter arbiter (
      .req(req),
      .lvl(lvl),
      .sel_valid(sel_valid),
      .sel_src(sel_src),
      .sel_lvl(sel_lvl)
   );

   // CPU side gating
   assign blocked = cpu.state[irq_pkg::STATE_BL_BIT];
   assign cpu_irq_mask_field = cpu.state[irq_pkg::STATE_CPU_IRQ_MASK_FIELD_LSB +: 4];
   assign acceptable = sel_valid && !blocked && (sel_lvl > {1'b0, cpu_irq_mask_field});
   assign bus_tick = (state_reg.div == irq_pkg::BUS_DIV - 4'h1);

   // Handshake and data outputs
   assign awready = !state_reg.aw_held;
   assign wready = !state_reg.w_held;
   assign bvalid = state_reg.b_valid;
   assign bresp = state_reg.b_resp;
   assign arready = !state_reg.r_valid;
   assign rvalid = state_reg.r_valid;
   assign rdata = state_reg.r_data;
   assign rresp = state_reg.r_resp;
   assign cpu_entry = state_reg.entry;
   assign irq_request = (state_reg.phase == irq_pkg::PH_WAIT);

   always_comb begin
      state_next = state_reg;
      state_next.entry.take = 1'b0;
      state_next.entry.fetch_start = 1'b0;
      state_next.nmi_prev = nmi_pin;
      state_next.div = bus_tick ? 4'h0 : state_reg.div + 4'h1;

      // Write channel
      if (awvalid && awready) begin
         state_next.aw_held = 1'b1;
         state_next.aw_addr = awaddr;
      end
      if (wvalid && wready) begin
         state_next.w_held = 1'b1;
         state_next.w_data = wdata;
         state_next.w_strb = wstrb;
      end
      if (state_reg.b_valid && bready) begin
         state_next.b_valid = 1'b0;
      end
      if (state_reg.aw_held && state_reg.w_held && !state_reg.b_valid) begin
         state_next.aw_held = 1'b0;
         state_next.w_held = 1'b0;
         state_next.b_valid = 1'b1;
         state_next.b_resp = mapped(state_reg.aw_addr) ? irq_pkg::RESP_OKAY : irq_pkg::RESP_SLVERR;
         case (state_reg.aw_addr)
            irq_pkg::OFF_SOURCE_MASK: begin
               state_next.source_mask = state_reg.source_mask
                  | (state_reg.w_data & byte_mask(state_reg.w_strb) & irq_pkg::SOURCE_BITS);
            end
            irq_pkg::OFF_MASK_CLEAR: begin
               state_next.source_mask = state_reg.source_mask
                  & ~(state_reg.w_data & byte_mask(state_reg.w_strb));
            end
            irq_pkg::OFF_LEVEL_SET: begin
               state_next.level_set = merge(state_reg.level_set, state_reg.w_data, state_reg.w_strb)
                  & irq_pkg::LEVEL_RW_MASK;
            end
            irq_pkg::OFF_CONTROL: begin
               state_next.control = merge(state_reg.control, state_reg.w_data, state_reg.w_strb)
                  & irq_pkg::CONTROL_RW_MASK;
            end
            default: begin
            end
         endcase
      end

      // Read channel
      if (state_reg.r_valid && rready) begin
         state_next.r_valid = 1'b0;
      end
      if (arvalid && arready) begin
         state_next.r_valid = 1'b1;
         state_next.r_resp = mapped(araddr) ? irq_pkg::RESP_OKAY : irq_pkg::RESP_SLVERR;
         case (araddr)
            irq_pkg::OFF_SOURCE_MASK: state_next.r_data = state_reg.source_mask;
            irq_pkg::OFF_MASK_CLEAR: state_next.r_data = 32'h00000000;
            irq_pkg::OFF_SOURCE_PENDING: state_next.r_data = pending;
            irq_pkg::OFF_LEVEL_SET: state_next.r_data = state_reg.level_set;
            irq_pkg::OFF_CONTROL: state_next.r_data = state_reg.control;
            irq_pkg::OFF_EVENT_CODE: state_next.r_data = state_reg.event_code;
            irq_pkg::OFF_SAVED_STATE: state_next.r_data = state_reg.entry.saved_state;
            irq_pkg::OFF_SAVED_PC: state_next.r_data = state_reg.entry.saved_pc;
            irq_pkg::OFF_SAVED_STACK: state_next.r_data = state_reg.entry.saved_stack;
            default: state_next.r_data = 32'h00000000;
         endcase
      end

      // Acceptance sequence
      case (state_reg.phase)
         irq_pkg::PH_IDLE: begin
            if (acceptable) begin
               state_next.phase = irq_pkg::PH_DECIDE;
               state_next.src = sel_src;
               state_next.count = bus_latency(sel_src);
            end
         end
         irq_pkg::PH_DECIDE: begin
            if (!acceptable || sel_src != state_reg.src) begin
               state_next.phase = irq_pkg::PH_IDLE;
            end else if (bus_tick) begin
               state_next.count = state_reg.count - 4'h1;
               if (state_reg.count == 4'h1) begin
                  state_next.phase = irq_pkg::PH_WAIT;
               end
            end
         end
         irq_pkg::PH_WAIT: begin
            if (!acceptable || sel_src != state_reg.src) begin
               state_next.phase = irq_pkg::PH_IDLE;
            end else if (cpu.boundary) begin
               state_next.phase = irq_pkg::PH_ENTRY;
               state_next.count = irq_pkg::ENTRY_CORE - 4'h1;
               state_next.event_code = event_of(state_reg.src);
               state_next.entry.saved_state = cpu.state;
               state_next.entry.saved_pc = cpu.pc;
               state_next.entry.saved_stack = cpu.stack;
               state_next.entry.new_state = cpu.state | (32'h00000001 << irq_pkg::STATE_BL_BIT)
                  | (32'h00000001 << irq_pkg::STATE_MD_BIT)
                  | (32'h00000001 << irq_pkg::STATE_RB_BIT);
               state_next.entry.fetch_addr = cpu.vbase + irq_pkg::HANDLER_OFFSET;
               state_next.entry.take = 1'b1;
               if (state_reg.src == irq_pkg::SRC_NMI) begin
                  state_next.nmi_pend = 1'b0;
               end
            end
         end
         irq_pkg::PH_ENTRY: begin
            state_next.count = state_reg.count - 4'h1;
            if (state_reg.count == 4'h1) begin
               state_next.entry.fetch_start = 1'b1;
               state_next.phase = irq_pkg::PH_IDLE;
            end
         end
         default: state_next.phase = irq_pkg::PH_IDLE;
      endcase

      // NMI edge; a new edge beats the acceptance clear
      if (nmi_edge && !(state_reg.control[irq_pkg::CONTROL_MAI_BIT] && standby_mode)) begin
         state_next.nmi_pend = 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_reg <= '0;
         state_reg.source_mask <= irq_pkg::MASK_RESET;
         state_reg.nmi_prev <= 1'b1;
         state_reg.phase <= irq_pkg::PH_IDLE;
         state_reg.src <= irq_pkg::SRC_NMI;
      end else begin
         state_reg <= state_next;
      end
   end

endmodule

// file: verif/irq_pma_sva.sv
// Port checker for the interrupt priority, mask and accept block
`timescale 1ns/1ps
module irq_pma_sva (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] araddr,
   input wire logic arvalid,
   input wire logic [31:0] rdata,
   input wire logic rvalid,
   input wire logic nmi_pin,
   input wire logic [3:0] encoded_request_pins,
   input wire logic timer3_underflow_irq,
   input wire logic timer4_underflow_irq,
   input wire irq_pkg::cpu_view_t cpu,
   input wire logic irq_request,
   input wire irq_pkg::cpu_entry_t cpu_entry
);
   localparam logic [31:0] SET_BITS = (32'h1 << irq_pkg::STATE_BL_BIT) | (32'h1 << irq_pkg::STATE_MD_BIT)
      | (32'h1 << irq_pkg::STATE_RB_BIT);
   logic take;
   logic any_src;
   assign take = cpu_entry.take;
   assign any_src = timer3_underflow_irq | timer4_underflow_irq | (encoded_request_pins != irq_pkg::ENC_IDLE);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   a_take_boundary: assert property (take |-> $past(irq_request && cpu.boundary))
      else $error("Acceptance without boundary and request");
   a_state_set: assert property (take |-> cpu_entry.new_state == ($past(cpu.state) | SET_BITS))
      else $error("New state bits wrong");
   a_state_saved: assert property (take |-> cpu_entry.saved_state == $past(cpu.state) &&
      cpu_entry.saved_pc == $past(cpu.pc) && cpu_entry.saved_stack == $past(cpu.stack))
      else $error("Saved registers wrong");
   a_fetch_addr: assert property (take |-> cpu_entry.fetch_addr == $past(cpu.vbase) + irq_pkg::HANDLER_OFFSET)
      else $error("Handler address wrong");
   a_entry_time: assert property (take |-> !cpu_entry.fetch_start [*3] ##1 cpu_entry.fetch_start)
      else $error("Entry length wrong");
   a_decide_time: assert property ($rose(irq_request) |-> $past(any_src, 3) || !$past(nmi_pin, 3))
      else $error("Request forwarded too early");
   a_clear_reads_zero: assert property ($rose(rvalid) && $past(arvalid && araddr == irq_pkg::OFF_MASK_CLEAR)
      |-> rdata == 32'h0)
      else $error("Mask clear readable");
   a_pending_live: assert property ($rose(rvalid) && $past(arvalid && araddr == irq_pkg::OFF_SOURCE_PENDING)
      |-> rdata == {22'h0, $past(timer4_underflow_irq), $past(timer3_underflow_irq), 8'h0})
      else $error("Pending bits wrong");
   c_take: cover property (take);
   c_nmi_take: cover property (take && !nmi_pin);
   c_enc_take: cover property (take && encoded_request_pins != irq_pkg::ENC_IDLE);
endmodule

bind irq_priority_mask_accept irq_pma_sva u_irq_pma_sva (.aclk(aclk), .aresetn(aresetn), .araddr(araddr),
   .arvalid(arvalid), .rdata(rdata), .rvalid(rvalid), .nmi_pin(nmi_pin), .encoded_request_pins(encoded_request_pins),
   .timer3_underflow_irq(timer3_underflow_irq), .timer4_underflow_irq(timer4_underflow_irq), .cpu(cpu),
   .irq_request(irq_request), .cpu_entry(cpu_entry));

// file: verif/cpu_model.sv
// Behavioural CPU core answering the interrupt block
`timescale 1ns/1ps
module cpu_model #(
   parameter logic [31:0] PC = 32'h00001000,
   parameter logic [31:0] STACK = 32'h0000a000,
   parameter logic [31:0] VBASE = 32'h8c000000
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [1:0] gap,
   input wire logic [31:0] st_val,
   input wire logic st_ld,
   input wire irq_pkg::cpu_entry_t cpu_entry,
   output irq_pkg::cpu_view_t cpu
);
   logic [31:0] state_reg;
   logic [1:0] cnt_reg;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_reg <= 32'h0;
         cnt_reg <= 2'h0;
      end else begin
         cnt_reg <= (cnt_reg >= gap) ? 2'h0 : cnt_reg + 2'h1;
         if (cpu_entry.take) begin
            state_reg <= cpu_entry.new_state;
         end else if (st_ld) begin
            state_reg <= st_val;
         end
      end
   end
   assign cpu = '{state: state_reg, pc: PC, stack: STACK, vbase: VBASE, boundary: cnt_reg == gap};
endmodule

// file: verif/tb_top.sv
// Self-checking bench for the interrupt priority, mask and accept block
`timescale 1ns/1ps
module tb_top;
   logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
   logic irq_request, nmi_pin, timer3_underflow_irq, timer4_underflow_irq, standby_mode, st_ld;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata, st_val, rd_d;
   logic [3:0] wstrb, encoded_request_pins;
   logic [1:0] bresp, rresp, gap, rr, br;
   irq_pkg::cpu_view_t cpu;
   irq_pkg::cpu_entry_t cpu_entry;
   int n_mismatch = 0;
   int tests_run = 0;
   int n_cyc;
   irq_priority_mask_accept u_irq_priority_mask_accept (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata,
      .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
      .rready, .nmi_pin, .encoded_request_pins, .timer3_underflow_irq, .timer4_underflow_irq, .standby_mode,
      .cpu, .irq_request, .cpu_entry);
   cpu_model u_cpu_model (.aclk, .aresetn, .gap, .st_val, .st_ld, .cpu_entry, .cpu);
   task automatic test_done;
      $display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      br = bresp;
      bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      rd_d = rdata;
      rr = rresp;
      rready <= 1'b0;
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
      rd(a);
      chk(rd_d, exp);
   endtask
   task automatic cpu_set(input logic [31:0] v);
      @(posedge aclk);
      st_val <= v;
      st_ld <= 1'b1;
      @(posedge aclk);
      st_ld <= 1'b0;
   endtask
   task automatic wait_take(input logic [31:0] evt);
      logic got;
      got = 1'b0;
      for (int i = 0; i < 80 && !got; i++) begin
         @(posedge aclk);
         got = (cpu_entry.take === 1'b1);
      end
      chk({31'h0, got}, 32'h1);
      rchk(irq_pkg::OFF_EVENT_CODE, evt);
   endtask
   task automatic no_take;
      logic got;
      got = 1'b0;
      repeat (40) begin
         @(posedge aclk);
         if (cpu_entry.take === 1'b1) got = 1'b1;
      end
      chk({31'h0, got}, 32'h0);
   endtask
   initial begin
      aclk = 1'b0;
      forever #50 aclk = ~aclk;
   end
   initial begin
      repeat (20000) @(posedge aclk);
      n_mismatch++;
      test_done;
   end
   initial begin
      {aresetn, awvalid, wvalid, bready, arvalid, rready, st_ld, standby_mode} = 8'h0;
      {timer3_underflow_irq, timer4_underflow_irq, awaddr, araddr, wdata, st_val, gap} = '0;
      nmi_pin = 1'b1;
      wstrb = 4'hf;
      encoded_request_pins = irq_pkg::ENC_IDLE;
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      rchk(irq_pkg::OFF_SOURCE_MASK, irq_pkg::MASK_RESET);
      rchk(irq_pkg::OFF_MASK_CLEAR, 32'h0);
      rd(8'h40);
      chk({30'h0, rr}, {30'h0, irq_pkg::RESP_SLVERR});
      wr(8'h40, 32'h0);
      chk({30'h0, br}, {30'h0, irq_pkg::RESP_SLVERR});
      wr(irq_pkg::OFF_SOURCE_MASK, 32'h0);
      chk({30'h0, br}, {30'h0, irq_pkg::RESP_OKAY});
      rchk(irq_pkg::OFF_SOURCE_MASK, irq_pkg::MASK_RESET);
      timer3_underflow_irq <= 1'b1;
      timer4_underflow_irq <= 1'b1;
      rchk(irq_pkg::OFF_SOURCE_PENDING, 32'h300);
      wr(irq_pkg::OFF_MASK_CLEAR, 32'h0);
      rchk(irq_pkg::OFF_SOURCE_MASK, irq_pkg::MASK_RESET);
      wr(irq_pkg::OFF_MASK_CLEAR, 32'h100);
      rchk(irq_pkg::OFF_SOURCE_MASK, 32'h2ff);
      no_take;
      wr(irq_pkg::OFF_MASK_CLEAR, 32'h200);
      wr(irq_pkg::OFF_LEVEL_SET, 32'h9500);
      wait_take(irq_pkg::EVT_TIMER4);
      rchk(irq_pkg::OFF_SAVED_PC, 32'h00001000);
      rchk(irq_pkg::OFF_SAVED_STATE, 32'h0);
      rchk(irq_pkg::OFF_SAVED_STACK, 32'h0000a000);
      timer4_underflow_irq <= 1'b0;
      rchk(irq_pkg::OFF_SOURCE_PENDING, 32'h100);
      cpu_set(32'h90);
      no_take;
      cpu_set(32'h40);
      wait_take(irq_pkg::EVT_TIMER3);
      timer4_underflow_irq <= 1'b1;
      gap <= 2'h3;
      wr(irq_pkg::OFF_LEVEL_SET, 32'h5500);
      cpu_set(32'h0);
      wait_take(irq_pkg::EVT_TIMER3);
      wr(irq_pkg::OFF_LEVEL_SET, 32'hf000);
      cpu_set(32'he0);
      wait_take(irq_pkg::EVT_TIMER4);
      wr(irq_pkg::OFF_LEVEL_SET, 32'h5500);
      wr(irq_pkg::OFF_SOURCE_MASK, 32'h100);
      cpu_set(32'h0);
      wait_take(irq_pkg::EVT_TIMER4);
      timer3_underflow_irq <= 1'b0;
      timer4_underflow_irq <= 1'b0;
      wr(irq_pkg::OFF_CONTROL, 32'h1);
      nmi_pin <= 1'b0;
      cpu_set(32'h0);
      wait_take(irq_pkg::EVT_NMI);
      timer3_underflow_irq <= 1'b1;
      timer4_underflow_irq <= 1'b1;
      cpu_set(32'h0);
      no_take;
      timer3_underflow_irq <= 1'b0;
      timer4_underflow_irq <= 1'b0;
      nmi_pin <= 1'b1;
      standby_mode <= 1'b1;
      repeat (3) @(posedge aclk);
      nmi_pin <= 1'b0;
      no_take;
      standby_mode <= 1'b0;
      nmi_pin <= 1'b1;
      wr(irq_pkg::OFF_CONTROL, 32'h0);
      encoded_request_pins <= 4'ha;
      n_cyc = 0;
      do begin
         @(posedge aclk);
         n_cyc++;
      end while (irq_request !== 1'b1 && n_cyc < 40);
      // One core cycle plus seven bus cycles, divider phase either way
      chk({31'h0, (n_cyc >= 15 && n_cyc <= 16)}, 32'h1);
      wait_take(irq_pkg::EVT_ENCODED);
      test_done;
   end
endmodule
